// [verilog/dscp_pkg.sv]
// Constants and carrier types for the lighting slave command processor.
// Assumes a 100 MHz system clock and a single synchronous reset.
package dscp_pkg;
  localparam int CLK_HZ = 100000000;
  localparam int TICK_MS = 1;
  localparam int TICK_CYC = CLK_HZ / 1000 * TICK_MS;
  localparam logic [16:0] TICK_LAST = 17'(TICK_CYC - 1);
  localparam int TEN_MS = 10;
  localparam logic [3:0] TEN_LAST = 4'(TEN_MS - 1);
  localparam int ANSWER_MS = 4;
  localparam int CONFIG_MS = 100;
  localparam int PROHIBIT_MS = 19;
  localparam int DAPC_MS = 200;
  localparam int IFAIL_MS = 500;
  localparam int ADDR_MIN = 15;
  localparam int ADDR_MS = ADDR_MIN * 60 * 1000;
  localparam int STATUS_FADE_BIT = 4;
  localparam int STATUS_LIMIT_BIT = 3;
  localparam logic [7:0] BCAST_MIN = 8'hfe;
  localparam logic [7:0] GROUP_MIN = 8'h80;
  localparam logic [7:0] GROUP_MAX = 8'h9f;
  localparam logic [7:0] CMD_CFG_FIRST = 8'h20;
  localparam logic [7:0] CMD_CFG_LAST = 8'h81;
  localparam logic [7:0] CMD_QUERY_FIRST = 8'h90;
  localparam logic [7:0] CMD_ENABLE_DAPC = 8'h09;
  localparam logic [7:0] SPECIAL_ADDR_FIRST = 8'ha1;
  localparam logic [7:0] SPECIAL_ADDR_LAST = 8'hb9;

  typedef enum logic [1:0] {DSCP_ADDR_BCAST, DSCP_ADDR_SHORT, DSCP_ADDR_GROUP,
                            DSCP_ADDR_SPECIAL} dscp_addr_kind_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] cmd;
  } dscp_frame_t;

  typedef struct packed {
    logic [7:0] min_level;
    logic [7:0] max_level;
    logic [7:0] fade_count;
    logic [5:0] short_addr;
    logic [15:0] groups;
  } dscp_cfg_t;
endpackage

// [verilog/dscp_down_counter.sv]
// Loadable millisecond down-counter with a one-cycle expiry pulse.
// Assumes tick is a one-cycle enable from the millisecond divider.
`timescale 1ns/100ps
`default_nettype none
module dscp_down_counter #(
  parameter int W = 20
) (
  input wire logic clk_sys, // System clock
  input wire logic rst, // Synchronous reset
  input wire logic tick, // Millisecond enable
  input wire logic load, // Load count
  input wire logic stop, // Abandon count
  input wire logic [W-1:0] value, // Count to load
  output logic running, // Counter nonzero
  output logic expired // Pulse on reaching zero
);
  typedef struct packed {
    logic [W-1:0] count;
    logic expired;
  } dscp_cnt_state_t;
  dscp_cnt_state_t state;
  dscp_cnt_state_t next_state;

  always_comb begin
    next_state = state;
    next_state.expired = 1'b0;
    if (load) begin
      next_state.count = value;
    end else if (stop) begin
      next_state.count = '0;
    end else if (tick && state.count != '0) begin
      next_state.count = state.count - W'(1);
      next_state.expired = (state.count == W'(1));
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign running = (state.count != '0);
  assign expired = state.expired;
endmodule
`default_nettype wire

// [verilog/dscp_core.sv]
// Command processor core of a lighting bus slave.
// Assumes receiver flags are one-cycle pulses synchronous to clk_sys, and
// that the store answers each save request with one done or fail pulse.
`timescale 1ns/100ps
`default_nettype none
module dscp_core #(
  parameter int ADDR_WINDOW_MS = dscp_pkg::ADDR_MS, // Addressing window
  parameter int TICK_CYCLES = dscp_pkg::TICK_CYC // Clock cycles per 1 ms tick
) (
  input wire logic clk_sys, // System clock
  input wire logic rst, // Synchronous reset
  input wire logic rx_complete_flag, // Frame received
  input wire logic rx_error_flag, // Frame received with error
  input wire dscp_pkg::dscp_frame_t rx_frame, // Received address and command
  input wire dscp_pkg::dscp_cfg_t cfg, // Configured levels and addresses
  input wire logic bus_level, // Bus line level, low is idle fault
  input wire logic random_busy, // Random address assignment active
  input wire logic addressing_start, // Initialise command seen
  input wire logic nvm_done, // Save completed
  input wire logic nvm_fail, // Save failed
  input wire logic cfg_changed, // Configuration data changed
  input wire logic tx_done, // Backward frame sent
  output logic [7:0] actual_level, // Current light level
  output logic [7:0] target_level, // Fade destination
  output logic [7:0] status_info, // Status information byte
  output logic rx_enable, // Reception allowed
  output logic answer_send, // Pulse: send backward frame now
  output logic light_cmd_valid, // Pulse: arc power command
  output logic config_cmd_valid, // Pulse: confirmed configuration
  output logic query_cmd_valid, // Pulse: query command
  output logic special_cmd_valid, // Pulse: special command
  output logic [7:0] cmd_out, // Command byte for handlers
  output logic addressing_open, // Addressing window open
  output logic nvm_save, // Pulse: request save
  output logic system_failure // System failure state
);
  typedef struct packed {
    logic [16:0] div;
    logic [3:0] ten;
    logic [7:0] actual;
    logic [7:0] target;
    logic [7:0] fade_left;
    logic fading;
    logic limit_err;
    logic save_pending;
    logic saving;
    logic failure;
    logic rx_enable;
    logic answer_pend;
    logic answer_send;
    logic light_v;
    logic config_v;
    logic query_v;
    logic special_v;
    logic [7:0] cmd;
    logic [7:0] last_cfg;
    logic nvm_save;
  } dscp_state_t;
  dscp_state_t state;
  dscp_state_t next_state;

  logic tick;
  logic ten_tick;
  logic good_frame;
  logic addressed;
  logic needs_answer;
  logic is_dapc;
  logic is_cfg;
  logic cfg_repeat;
  logic [7:0] clamped;
  dscp_pkg::dscp_addr_kind_t kind;
  logic ans_run, ans_exp, cfg_run, pro_run, pro_exp, dapc_run, if_exp, adr_run;
  logic load_dapc;
  logic if_run_q;

  // Shorter tick only for fast simulation; hardware keeps the default
  assign tick = (state.div == 17'(TICK_CYCLES - 1));
  assign ten_tick = tick && (state.ten == dscp_pkg::TEN_LAST);

  // Frames arriving while reception is refused are dropped here
  assign good_frame = rx_complete_flag && !rx_error_flag && state.rx_enable;

  always_comb begin
    if (rx_frame.addr >= dscp_pkg::BCAST_MIN) begin
      kind = dscp_pkg::DSCP_ADDR_BCAST;
    end else if (rx_frame.addr < dscp_pkg::GROUP_MIN) begin
      kind = dscp_pkg::DSCP_ADDR_SHORT;
    end else if (rx_frame.addr <= dscp_pkg::GROUP_MAX) begin
      kind = dscp_pkg::DSCP_ADDR_GROUP;
    end else begin
      kind = dscp_pkg::DSCP_ADDR_SPECIAL;
    end
  end

  always_comb begin
    unique case (kind)
      dscp_pkg::DSCP_ADDR_BCAST: addressed = 1'b1;
      dscp_pkg::DSCP_ADDR_SHORT: addressed = (rx_frame.addr[6:1] == cfg.short_addr);
      dscp_pkg::DSCP_ADDR_GROUP: addressed = cfg.groups[rx_frame.addr[4:1]];
      dscp_pkg::DSCP_ADDR_SPECIAL: addressed = 1'b0;
    endcase
  end

  // Selector bit clear means direct arc power, low byte is the level
  assign is_dapc = !rx_frame.addr[0];
  assign is_cfg = rx_frame.addr[0] && rx_frame.cmd >= dscp_pkg::CMD_CFG_FIRST
                  && rx_frame.cmd <= dscp_pkg::CMD_CFG_LAST;
  assign needs_answer = good_frame && addressed && rx_frame.addr[0]
                        && rx_frame.cmd >= dscp_pkg::CMD_QUERY_FIRST;
  assign cfg_repeat = cfg_run && (rx_frame.cmd == state.last_cfg);

  always_comb begin
    if (rx_frame.cmd < cfg.min_level) begin
      clamped = cfg.min_level;
    end else if (rx_frame.cmd > cfg.max_level) begin
      clamped = cfg.max_level;
    end else begin
      clamped = rx_frame.cmd;
    end
  end

  assign load_dapc = good_frame && addressed && (is_dapc
                     || (rx_frame.addr[0] && rx_frame.cmd == dscp_pkg::CMD_ENABLE_DAPC));

  dscp_down_counter #(.W(20)) u_answer (
    .clk_sys(clk_sys), .rst(rst), .tick(tick),
    .load(needs_answer), .stop(1'b0),
    .value(20'(dscp_pkg::ANSWER_MS)), .running(ans_run), .expired(ans_exp));
  dscp_down_counter #(.W(20)) u_config (
    .clk_sys(clk_sys), .rst(rst), .tick(tick),
    .load(good_frame && addressed && is_cfg && !cfg_repeat),
    .stop(good_frame && addressed && is_cfg && cfg_repeat),
    .value(20'(dscp_pkg::CONFIG_MS)), .running(cfg_run), .expired());
  dscp_down_counter #(.W(20)) u_prohibit (
    .clk_sys(clk_sys), .rst(rst), .tick(tick),
    .load(needs_answer), .stop(1'b0),
    .value(20'(dscp_pkg::PROHIBIT_MS)), .running(pro_run), .expired(pro_exp));
  dscp_down_counter #(.W(20)) u_dapc (
    .clk_sys(clk_sys), .rst(rst), .tick(tick),
    .load(load_dapc), .stop(nvm_fail),
    .value(20'(dscp_pkg::DAPC_MS)), .running(dapc_run), .expired());
  dscp_down_counter #(.W(20)) u_iface (
    .clk_sys(clk_sys), .rst(rst), .tick(tick),
    .load(bus_level || (!bus_level && !if_run_q)), .stop(1'b0),
    .value(20'(dscp_pkg::IFAIL_MS)), .running(), .expired(if_exp));
  dscp_down_counter #(.W(20)) u_addr (
    .clk_sys(clk_sys), .rst(rst), .tick(tick),
    .load(addressing_start), .stop(1'b0),
    .value(20'(ADDR_WINDOW_MS)), .running(adr_run), .expired());

  // Low-level watch arms once per low period; high reloads it every cycle
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      if_run_q <= 1'b0;
    end else begin
      if_run_q <= !bus_level;
    end
  end

  always_comb begin
    next_state = state;
    next_state.answer_send = 1'b0;
    next_state.light_v = 1'b0;
    next_state.config_v = 1'b0;
    next_state.query_v = 1'b0;
    next_state.special_v = 1'b0;
    next_state.nvm_save = 1'b0;
    // Completion first, so any change in the same cycle keeps the flag set
    if (nvm_done) begin
      next_state.saving = 1'b0;
      next_state.save_pending = 1'b0;
    end
    if (tx_done) begin
      next_state.answer_pend = 1'b0;
    end
    next_state.div = tick ? '0 : state.div + 17'h00001;
    if (tick) begin
      next_state.ten = (state.ten == dscp_pkg::TEN_LAST) ? '0 : state.ten + 4'h1;
    end
    if (good_frame) begin
      next_state.cmd = rx_frame.cmd;
      if (kind == dscp_pkg::DSCP_ADDR_SPECIAL) begin
        next_state.special_v = 1'b1;
      end else if (addressed) begin
        if (is_dapc) begin
          next_state.target = clamped;
          next_state.limit_err = (rx_frame.cmd != clamped);
          if (state.actual == 8'h00) begin
            next_state.actual = clamped;
            next_state.save_pending = 1'b1;
          end else if (cfg.fade_count == 8'h00) begin
            next_state.actual = clamped;
            next_state.save_pending = 1'b1;
          end else begin
            next_state.fade_left = cfg.fade_count;
          end
        end else if (is_cfg) begin
          next_state.last_cfg = rx_frame.cmd;
          next_state.config_v = cfg_repeat;
        end else if (rx_frame.cmd >= dscp_pkg::CMD_QUERY_FIRST) begin
          next_state.query_v = 1'b1;
        end else begin
          next_state.light_v = 1'b1;
        end
      end
    end
    if (needs_answer) begin
      next_state.answer_pend = 1'b1;
      next_state.rx_enable = 1'b0;
    end
    if (ans_exp && state.answer_pend) begin
      next_state.answer_send = 1'b1;
    end
    if (pro_exp) begin
      next_state.rx_enable = 1'b1;
    end
    // Fade divides the remaining distance by the remaining 10 ms slots
    if (ten_tick && state.actual != state.target && !(good_frame && is_dapc)) begin
      if (state.fade_left <= 8'h01) begin
        next_state.actual = state.target;
      end else if (state.actual < state.target) begin
        next_state.actual = state.actual + 8'((state.target - state.actual) / state.fade_left);
      end else begin
        next_state.actual = state.actual - 8'((state.actual - state.target) / state.fade_left);
      end
      if (state.fade_left != 8'h00) begin
        next_state.fade_left = state.fade_left - 8'h01;
      end
      next_state.save_pending = 1'b1;
    end
    next_state.fading = (next_state.actual != next_state.target);
    if (cfg_changed) begin
      next_state.save_pending = 1'b1;
    end
    // A query taken this cycle also blocks the save
    if (state.save_pending && !state.saving && !state.answer_pend && !ans_run
        && !needs_answer && !random_busy) begin
      next_state.nvm_save = 1'b1;
      next_state.saving = 1'b1;
    end
    if (nvm_fail || if_exp) begin
      next_state.saving = nvm_fail ? 1'b0 : state.saving;
      next_state.failure = 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state <= '0;
      state.rx_enable <= 1'b1;
    end else begin
      state <= next_state;
    end
  end

  logic [7:0] status_q;
  logic adr_q;
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      status_q <= '0;
      adr_q <= 1'b0;
    end else begin
      status_q <= '0;
      status_q[dscp_pkg::STATUS_FADE_BIT] <= next_state.fading;
      status_q[dscp_pkg::STATUS_LIMIT_BIT] <= next_state.limit_err;
      adr_q <= adr_run;
    end
  end

  assign actual_level = state.actual;
  assign target_level = state.target;
  assign status_info = status_q;
  assign rx_enable = state.rx_enable;
  assign answer_send = state.answer_send;
  assign light_cmd_valid = state.light_v;
  assign config_cmd_valid = state.config_v;
  assign query_cmd_valid = state.query_v;
  assign special_cmd_valid = state.special_v;
  assign cmd_out = state.cmd;
  assign addressing_open = adr_q;
  assign nvm_save = state.nvm_save;
  assign system_failure = state.failure;
  logic unused_ok;
  assign unused_ok = dapc_run ^ pro_run;
endmodule
`default_nettype wire

// [verification/dscp_master_model.sv]
// Forward frame source standing in for the bus master.
// Assumes go is high for one cycle per frame.
`timescale 1ns/100ps
`default_nettype none
module dscp_master_model (
  input wire logic clk_sys, // Clock
  input wire logic go, // Send frame
  input wire logic bad, // Mark as errored
  input wire dscp_pkg::dscp_frame_t frame, // Frame to send
  output logic rx_complete_flag, // Frame done
  output logic rx_error_flag, // Frame bad
  output dscp_pkg::dscp_frame_t rx_frame // Frame data
);
  // Data toggles between frames so a stale frame never looks valid
  always_ff @(posedge clk_sys) begin
    rx_complete_flag <= go;
    rx_error_flag <= go & bad;
    rx_frame <= go ? frame : ~rx_frame;
  end
endmodule
`default_nettype wire

// [verification/dscp_core_properties.sv]
// Port checker for the command processor core.
// Assumes a bind onto dscp_core, 100 MHz clock.
`timescale 1ns/100ps
`default_nettype none
module dscp_core_properties #(
  parameter int ADDR_WINDOW_MS = 50, // Window
  parameter int TICK_CYCLES = dscp_pkg::TICK_CYC // Cycles per tick
) (
  input wire logic clk_sys, // Clock
  input wire logic rst, // Reset
  input wire logic rx_complete_flag, // Frame
  input wire logic rx_error_flag, // Bad
  input wire dscp_pkg::dscp_frame_t rx_frame, // Data
  input wire dscp_pkg::dscp_cfg_t cfg, // Config
  input wire logic random_busy, // Randomise
  input wire logic nvm_fail, // Save failed
  input wire logic tx_done, // Answered
  input wire logic [7:0] target_level, // Target
  input wire logic rx_enable, // Rx on
  input wire logic answer_send, // Answer
  input wire logic light_cmd_valid, // Arc
  input wire logic config_cmd_valid, // Config
  input wire logic query_cmd_valid, // Query
  input wire logic special_cmd_valid, // Special
  input wire logic [7:0] cmd_out, // Cmd
  input wire logic nvm_save, // Save
  input wire logic system_failure // Failure
);
  // Tick phase makes waits up to one ms short
  localparam int HOLD_MIN = (dscp_pkg::PROHIBIT_MS - 1) * TICK_CYCLES - 10;
  localparam int ANS_MIN = (dscp_pkg::ANSWER_MS - 1) * TICK_CYCLES - 10;
  localparam int ANS_MAX = dscp_pkg::ANSWER_MS * TICK_CYCLES + 10;
  int low_cnt;
  int ans_cnt;
  logic pend;
  logic [7:0] req;
  logic take;
  logic is_q;
  logic is_sp;
  logic is_arc;
  assign take = rx_complete_flag && !rx_error_flag && rx_enable;
  assign is_q = rx_frame.addr == 8'hff && rx_frame.cmd >= dscp_pkg::CMD_QUERY_FIRST;
  assign is_sp = rx_frame.addr inside
    {[dscp_pkg::SPECIAL_ADDR_FIRST:dscp_pkg::SPECIAL_ADDR_LAST]};
  assign is_arc = rx_frame.addr == 8'hfe && rx_frame.cmd != 8'h00 && rx_frame.cmd != 8'hff;
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      low_cnt <= 0;
      ans_cnt <= 0;
      pend <= 1'b0;
      req <= 8'h00;
    end else begin
      low_cnt <= rx_enable ? 0 : low_cnt + 1;
      ans_cnt <= (take && is_q) ? 0 : ans_cnt + 1;
      pend <= (take && is_q) || (pend && !tx_done);
      req <= take ? rx_frame.cmd : req;
    end
  end
  function automatic logic [7:0] lim(logic [7:0] v);
    return v < cfg.min_level ? cfg.min_level : (v > cfg.max_level ? cfg.max_level : v);
  endfunction
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  sequence s_query;
    take && is_q;
  endsequence
  sequence s_arc;
    take && is_arc;
  endsequence
  chk_error_refused: assert property (rx_complete_flag && rx_error_flag |=>
    !(light_cmd_valid || config_cmd_valid || query_cmd_valid || special_cmd_valid))
    else $error("errored frame acted on");
  chk_special_route: assert property (take && is_sp |=>
    special_cmd_valid && cmd_out == $past(rx_frame.cmd)) else $error("special not routed");
  chk_query_route: assert property (s_query |=> query_cmd_valid && !rx_enable)
    else $error("query not routed");
  chk_rx_hold: assert property ($rose(rx_enable) |-> low_cnt >= HOLD_MIN)
    else $error("reception reopened early");
  chk_answer_wait: assert property (answer_send |-> ans_cnt inside {[ANS_MIN:ANS_MAX]})
    else $error("answer timing off");
  chk_clamp_target: assert property (s_arc |-> ##[1:2] target_level == lim(req))
    else $error("target not clamped");
  chk_save_guard: assert property (nvm_save |-> !random_busy && !pend)
    else $error("save while blocked");
  chk_fail_raise: assert property (nvm_fail |-> ##[1:2] system_failure)
    else $error("failure not raised");
endmodule
`default_nettype wire

// [verification/dscp_core_tb_top.sv]
// Self-checking bench for the command processor core.
// Assumes the master model and checker are compiled first.
`timescale 1ns/100ps
`default_nettype none
module dscp_core_tb_top;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic go = 1'b0;
  logic bad = 1'b0;
  logic clr = 1'b0;
  logic fail_mode = 1'b0;
  localparam int TK = 20;
  logic random_busy = 1'b0;
  logic bus_level = 1'b1;
  logic addressing_start = 1'b0;
  logic nvm_done = 1'b0;
  logic nvm_fail = 1'b0;
  logic cfg_changed = 1'b0;
  logic tx_done = 1'b0;
  dscp_pkg::dscp_frame_t frame = 16'h0000;
  dscp_pkg::dscp_frame_t rx_frame;
  dscp_pkg::dscp_cfg_t cfg = {8'h20, 8'hd0, 8'h00, 6'h05, 16'h0010};
  logic rx_complete_flag, rx_error_flag, rx_enable, answer_send, addressing_open;
  logic light_cmd_valid, config_cmd_valid, query_cmd_valid, special_cmd_valid;
  logic nvm_save, system_failure;
  logic [7:0] actual_level, target_level, status_info, cmd_out, lv;
  logic [3:0] seen;
  logic [7:0] ta [5] = '{8'hff, 8'h0b, 8'h13, 8'h89, 8'ha3};
  logic [3:0] te [5] = '{4'h8, 4'h8, 4'h0, 4'h8, 4'h1};
  int saves = 0;
  int miscompares = 0;
  int cmp_count = 0;
  int cyc = 0;
  int n, m, seed;
  dscp_master_model u_master (.clk_sys(clk_sys), .go(go), .bad(bad), .frame(frame),
    .rx_complete_flag(rx_complete_flag), .rx_error_flag(rx_error_flag), .rx_frame(rx_frame));
  dscp_core #(.ADDR_WINDOW_MS(50), .TICK_CYCLES(TK)) DUT (.clk_sys(clk_sys), .rst(rst),
    .rx_complete_flag(rx_complete_flag), .rx_error_flag(rx_error_flag), .rx_frame(rx_frame),
    .cfg(cfg), .bus_level(bus_level), .random_busy(random_busy),
    .addressing_start(addressing_start),
    .nvm_done(nvm_done), .nvm_fail(nvm_fail), .cfg_changed(cfg_changed), .tx_done(tx_done),
    .actual_level(actual_level), .target_level(target_level), .status_info(status_info),
    .rx_enable(rx_enable), .answer_send(answer_send), .light_cmd_valid(light_cmd_valid),
    .config_cmd_valid(config_cmd_valid), .query_cmd_valid(query_cmd_valid),
    .special_cmd_valid(special_cmd_valid), .cmd_out(cmd_out),
    .addressing_open(addressing_open), .nvm_save(nvm_save), .system_failure(system_failure));
  initial begin
    forever #5 clk_sys = ~clk_sys;
  end
  task automatic summarize();
    $display("checks %0d miscompares %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // Store responder and pulse catcher; the ceiling covers the 500 ms bus-low wait
  always @(posedge clk_sys) begin
    seen <= clr ? 4'h0 : seen | {light_cmd_valid, config_cmd_valid, query_cmd_valid,
      special_cmd_valid};
    nvm_done <= nvm_save && !fail_mode;
    nvm_fail <= nvm_save && fail_mode;
    saves <= (nvm_save === 1'b1) ? saves + 1 : saves;
    cyc = cyc + 1;
    if (cyc == 40000) begin
      miscompares++;
      summarize();
    end
  end
  task automatic chk(string nm, logic [31:0] got, logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic step(int k);
    repeat (k) @(posedge clk_sys);
    #1;
  endtask
  task automatic send(logic [7:0] a, logic [7:0] c, logic e);
    clr = 1'b1;
    frame = {a, c};
    bad = e;
    go = 1'b1;
    step(1);
    go = 1'b0;
    clr = 1'b0;
    step(4);
  endtask
  function automatic logic [7:0] lim(logic [7:0] v);
    return v < cfg.min_level ? cfg.min_level : (v > cfg.max_level ? cfg.max_level : v);
  endfunction
  initial begin
    seed = 32'h6d53;
    step(20);
    chk("rx_enable", rx_enable, 1);
    rst = 1'b0;
    step(1);
    send(8'hff, 8'h90, 1'b1);
    chk("error pulses", seen, 4'h0);
    chk("error rx", rx_enable, 1);
    for (int i = 0; i < 5; i++) begin
      send(ta[i], 8'h05, 1'b0);
      chk("route", seen, te[i]);
      chk("cmd_out", cmd_out, 8'h05);
    end
    for (int i = 0; i < 10; i++) begin
      lv = i == 0 ? 8'h01 : (i == 1 ? 8'hfe : 8'($random(seed)));
      if (lv == 8'h00 || lv == 8'hff) begin
        lv = 8'h80;
      end
      send(8'hfe, lv, 1'b0);
      chk("target", target_level, lim(lv));
      chk("actual", actual_level, lim(lv));
      chk("fading", status_info[dscp_pkg::STATUS_FADE_BIT], 0);
    end
    send(8'hff, 8'h20, 1'b0);
    chk("config once", seen, 4'h0);
    send(8'hff, 8'h20, 1'b0);
    chk("config twice", seen, 4'h4);
    step(100);
    random_busy = 1'b1;
    n = saves;
    cfg_changed = 1'b1;
    step(1);
    cfg_changed = 1'b0;
    step(200);
    chk("save blocked", saves, n);
    random_busy = 1'b0;
    step(2000);
    chk("save done", saves, n + 1);
    send(8'hff, 8'h90, 1'b0);
    chk("query", seen, 4'h2);
    chk("rx off", rx_enable, 0);
    send(8'hff, 8'h05, 1'b0);
    chk("refused", seen, 4'h0);
    m = saves;
    cfg_changed = 1'b1;
    step(1);
    cfg_changed = 1'b0;
    n = 9;
    while (answer_send !== 1'b1 && n < dscp_pkg::ANSWER_MS * TK + 100) begin
      step(1);
      n++;
    end
    chk("answer wait", n >= (dscp_pkg::ANSWER_MS - 1) * TK - 10
      && n <= dscp_pkg::ANSWER_MS * TK + 10, 1);
    chk("save held", saves, m);
    tx_done = 1'b1;
    step(1);
    tx_done = 1'b0;
    while (rx_enable !== 1'b1 && n < dscp_pkg::PROHIBIT_MS * TK + 100) begin
      step(1);
      n++;
    end
    chk("rx hold", n >= (dscp_pkg::PROHIBIT_MS - 1) * TK - 10, 1);
    chk("save after", saves, m + 1);
    addressing_start = 1'b1;
    step(1);
    addressing_start = 1'b0;
    step(2);
    chk("addr open", addressing_open, 1);
    fail_mode = 1'b1;
    cfg_changed = 1'b1;
    step(1);
    cfg_changed = 1'b0;
    step(2000);
    chk("failure", system_failure, 1);
    rst = 1'b1;
    step(2);
    rst = 1'b0;
    step(1);
    chk("failure cleared", system_failure, 0);
    bus_level = 1'b0;
    step((dscp_pkg::IFAIL_MS - 10) * TK);
    chk("bus low early", system_failure, 0);
    step(20 * TK);
    chk("bus low failure", system_failure, 1);
    summarize();
  end
endmodule
bind dscp_core dscp_core_properties #(.ADDR_WINDOW_MS(ADDR_WINDOW_MS),
  .TICK_CYCLES(TICK_CYCLES)) u_chk (
  .clk_sys(clk_sys), .rst(rst), .rx_complete_flag(rx_complete_flag),
  .rx_error_flag(rx_error_flag), .rx_frame(rx_frame), .cfg(cfg), .random_busy(random_busy),
  .nvm_fail(nvm_fail), .tx_done(tx_done), .target_level(target_level), .rx_enable(rx_enable),
  .answer_send(answer_send), .light_cmd_valid(light_cmd_valid),
  .config_cmd_valid(config_cmd_valid), .query_cmd_valid(query_cmd_valid),
  .special_cmd_valid(special_cmd_valid), .cmd_out(cmd_out), .nvm_save(nvm_save),
  .system_failure(system_failure));
`default_nettype wire
